// >>> hdl/adcwin_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - reserved register bits always read zero
// - window mode zero disables; codes 5-7 reserved
// - mode 1 flags result above lower
// - mode 2 flags result below upper
// - mode 3 flags result strictly inside window
// - mode 4 flags result outside window
// - start bit begins conversion, clears when started
// - zero writes do nothing; a start written mid-conversion queues one more
// - flush restarts converter clock, aborts conversions
// - flush bit stays set until flush done
// - after flush, pending request starts new conversion
// - gain field coding, reserved codes flagged
// - scan active when channel count nonzero
// - first conversion uses base plus offset
// - offset increments after each conversion
// - scan covers count plus one inputs
// - negative select pins, ground codes, reserved
// - registers write-protected and write-synchronized
// - positive select pins and internal sources
// - window hit emits event when enabled
// - continuous mode restarts after each conversion
module adcwin_ctrl (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // write protection from the system
  input  wire logic        write_protect,
  // converter core
  output logic             conv_start,
  output logic             conv_flush,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_result,
  output logic      [4:0]  mux_pos,
  output logic      [4:0]  mux_neg,
  output logic      [3:0]  gain_code,
  output logic             sel_invalid,
  // events
  output logic             window_hit_event
);

  // ==================================================================
  // state names from the package
  typedef adcwin_pkg::adcwin_state_t adcwin_state_t;
  localparam adcwin_state_t ADCWIN_IDLE  = adcwin_pkg::ADCWIN_IDLE;
  localparam adcwin_state_t ADCWIN_CONV  = adcwin_pkg::ADCWIN_CONV;
  localparam adcwin_state_t ADCWIN_FLUSH = adcwin_pkg::ADCWIN_FLUSH;
  localparam adcwin_state_t ADCWIN_RESUM = adcwin_pkg::ADCWIN_RESUM;

  // ==================================================================
  // registers
  logic [2:0]  win_mode_ff;
  logic [1:0]  trig_ff;
  logic [31:0] input_ff;
  logic [1:0]  config_ff;
  logic [31:0] thresh_ff;
  logic [31:0] reg_rdata_ff;
  logic        pending_ff;
  logic [1:0]  flush_cnt_ff;
  logic        conv_start_ff;
  logic        event_ff;
  logic        busy_sync_ff;
  adcwin_state_t state_ff;
  adcwin_state_t nxt_state;

  logic        wr_ok;
  logic        hit;
  logic        flush_req;
  logic [3:0]  offset;
  logic [3:0]  scan_cnt;
  logic [4:0]  pos_base;
  logic        gain_bad;
  logic        neg_bad;
  logic        pos_bad;

  // ==================================================================
  // helpers
  function automatic logic window_check(input logic [2:0] mode, input logic [15:0] v,
                                        input logic [15:0] lo, input logic [15:0] hi);
    logic in_win;
    in_win = (v > lo) && (v < hi);
    case (mode)
      adcwin_pkg::WIN_ABOVE: window_check = v > lo;
      adcwin_pkg::WIN_BELOW: window_check = v < hi;
      adcwin_pkg::WIN_IN:    window_check = in_win;
      adcwin_pkg::WIN_OUT:   window_check = !in_win;
      default:               window_check = 1'b0;
    endcase
  endfunction

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = reg_wr && wr_ok && (reg_addr == a);
  endfunction

  assign wr_ok = !write_protect;

  assign offset   = input_ff[adcwin_pkg::OFFS_LSB +: 4];
  assign scan_cnt = input_ff[adcwin_pkg::SCAN_LSB +: 4];
  assign pos_base = input_ff[adcwin_pkg::POS_LSB +: 5];
  // flush writes during a running flush only set the bit; resume clears it
  assign flush_req = wr_hit(adcwin_pkg::ADDR_TRIGGER) && reg_wdata[adcwin_pkg::TRIG_FLUSH];

  // ==================================================================
  // window control
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      win_mode_ff <= adcwin_pkg::WIN_OFF;
    end else if (wr_hit(adcwin_pkg::ADDR_WINCMP)) begin
      win_mode_ff <= reg_wdata[adcwin_pkg::WIN_MODE_W-1:0];
    end
  end

  // ==================================================================
  // config and thresholds
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      config_ff <= '0;
      thresh_ff <= adcwin_pkg::RESET_WORD;
    end else begin
      if (wr_hit(adcwin_pkg::ADDR_CONFIG)) begin
        config_ff <= reg_wdata[1:0];
      end
      if (wr_hit(adcwin_pkg::ADDR_THRESH)) begin
        thresh_ff <= reg_wdata;
      end
    end
  end

  // ==================================================================
  // input control with scan offset
  // limitation: a software write during a conversion overwrites the offset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      input_ff <= adcwin_pkg::RESET_WORD;
    end else if (wr_hit(adcwin_pkg::ADDR_INPUT)) begin
      input_ff <= reg_wdata & adcwin_pkg::MASK_INPUT;
    end else if (conv_done && state_ff == ADCWIN_CONV && !flush_req && scan_cnt != 4'h0) begin
      if (offset >= scan_cnt) begin
        input_ff[adcwin_pkg::OFFS_LSB +: 4] <= 4'h0;
      end else begin
        input_ff[adcwin_pkg::OFFS_LSB +: 4] <= offset + 4'h1;
      end
    end
  end

  // positive input is base plus offset
  assign mux_pos   = pos_base + {1'b0, offset};
  assign mux_neg   = input_ff[adcwin_pkg::NEG_LSB +: 5];
  assign gain_code = input_ff[adcwin_pkg::GAIN_LSB +: 4];

  // gain codes 5 to 14 reserved
  assign gain_bad = (gain_code > adcwin_pkg::GAIN_X16) && (gain_code != adcwin_pkg::GAIN_HALF);
  // negative codes beside pins and grounds
  assign neg_bad  = (mux_neg > adcwin_pkg::NEG_PIN_MAX) && (mux_neg != adcwin_pkg::NEG_GND)
                 && (mux_neg != adcwin_pkg::NEG_IOGND);
  assign pos_bad  = ((mux_pos > adcwin_pkg::POS_PIN_MAX) && (mux_pos < adcwin_pkg::POS_INT_LO))
                 || (mux_pos > adcwin_pkg::POS_INT_HI);
  assign sel_invalid = gain_bad || neg_bad || pos_bad;

  // ==================================================================
  // conversion sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ADCWIN_IDLE: begin
        if (flush_req) begin
          nxt_state = ADCWIN_FLUSH;
        end else if (trig_ff[adcwin_pkg::TRIG_START]) begin
          nxt_state = ADCWIN_CONV;
        end
      end
      ADCWIN_CONV: begin
        if (flush_req) begin
          nxt_state = ADCWIN_FLUSH;
        end else if (conv_done) begin
          nxt_state = ADCWIN_IDLE;
        end
      end
      ADCWIN_FLUSH: begin
        if (flush_cnt_ff == 2'(adcwin_pkg::FLUSH_CYCLES - 1)) begin
          nxt_state = ADCWIN_RESUM;
        end
      end
      ADCWIN_RESUM: begin
        nxt_state = ADCWIN_IDLE;
      end
      default: nxt_state = ADCWIN_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_ff <= ADCWIN_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flush_cnt_ff <= '0;
    end else if (state_ff == ADCWIN_FLUSH) begin
      flush_cnt_ff <= flush_cnt_ff + 2'h1;
    end else begin
      flush_cnt_ff <= '0;
    end
  end

  // pending request survives a flush
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pending_ff <= 1'b0;
    end else if (flush_req && state_ff == ADCWIN_CONV) begin
      pending_ff <= 1'b1;
    end else if (state_ff == ADCWIN_RESUM) begin
      pending_ff <= 1'b0;
    end
  end

  // ==================================================================
  // software trigger bits
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      trig_ff <= 2'b00;
    end else begin
      if (state_ff == ADCWIN_IDLE && nxt_state == ADCWIN_CONV) begin
        trig_ff[adcwin_pkg::TRIG_START] <= 1'b0;
      end
      if (state_ff == ADCWIN_CONV && conv_done && !flush_req
          && config_ff[adcwin_pkg::CFG_CONTIN]) begin
        trig_ff[adcwin_pkg::TRIG_START] <= 1'b1;
      end
      if (state_ff == ADCWIN_RESUM && pending_ff) begin
        trig_ff[adcwin_pkg::TRIG_START] <= 1'b1;
      end
      if (state_ff == ADCWIN_RESUM) begin
        trig_ff[adcwin_pkg::TRIG_FLUSH] <= 1'b0;
      end
      // only ones take effect; set wins
      if (wr_hit(adcwin_pkg::ADDR_TRIGGER)) begin
        if (reg_wdata[adcwin_pkg::TRIG_START]) begin
          trig_ff[adcwin_pkg::TRIG_START] <= 1'b1;
        end
        if (reg_wdata[adcwin_pkg::TRIG_FLUSH]) begin
          trig_ff[adcwin_pkg::TRIG_FLUSH] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      conv_start_ff <= 1'b0;
    end else begin
      // registered so the core sees a clean one-cycle pulse
      conv_start_ff <= (state_ff == ADCWIN_IDLE) && (nxt_state == ADCWIN_CONV);
    end
  end

  assign conv_start = conv_start_ff;
  assign conv_flush = (state_ff == ADCWIN_FLUSH);

  // ==================================================================
  // window monitor
  // trade-off: plain unsigned compare; signed results need sign folding
  // evaluated only on a completed result
  assign hit = conv_done && (state_ff == ADCWIN_CONV) && !flush_req
            && window_check(win_mode_ff, conv_result,
                            thresh_ff[adcwin_pkg::THR_LO_LSB +: 16],
                            thresh_ff[adcwin_pkg::THR_HI_LSB +: 16]);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      event_ff <= 1'b0;
    end else begin
      event_ff <= hit && config_ff[adcwin_pkg::CFG_WINEO];
    end
  end

  assign window_hit_event = event_ff;

  // ==================================================================
  // status of sequencer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy_sync_ff <= 1'b0;
    end else begin
      busy_sync_ff <= (state_ff != ADCWIN_IDLE) || (trig_ff != 2'b00);
    end
  end

  // ==================================================================
  // read port, one cycle latency
  // data are zero outside the answer cycle so bus or-ing stays safe
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata_ff <= adcwin_pkg::RESET_WORD;
    end else if (reg_rd) begin
      case (reg_addr)
        adcwin_pkg::ADDR_WINCMP:  reg_rdata_ff <= {29'h0, win_mode_ff};
        adcwin_pkg::ADDR_TRIGGER: reg_rdata_ff <= {30'h0, trig_ff};
        adcwin_pkg::ADDR_INPUT:   reg_rdata_ff <= input_ff;
        adcwin_pkg::ADDR_CONFIG:  reg_rdata_ff <= {30'h0, config_ff};
        adcwin_pkg::ADDR_THRESH:  reg_rdata_ff <= thresh_ff;
        adcwin_pkg::ADDR_STATUS:  reg_rdata_ff <= {26'h0, sel_invalid, busy_sync_ff,
                                                   state_ff};
        default:                  reg_rdata_ff <= adcwin_pkg::RESET_WORD;
      endcase
    end else begin
      reg_rdata_ff <= adcwin_pkg::RESET_WORD;
    end
  end

  assign reg_rdata = reg_rdata_ff;

endmodule

// >>> pkg/adcwin_pkg.sv
package adcwin_pkg;

  // ==================================================================
  // register map
  localparam logic [7:0] ADDR_WINCMP   = 8'h08;
  localparam logic [7:0] ADDR_TRIGGER  = 8'h0c;
  localparam logic [7:0] ADDR_INPUT    = 8'h10;
  localparam logic [7:0] ADDR_CONFIG   = 8'h14;
  localparam logic [7:0] ADDR_THRESH   = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;

  // ==================================================================
  // field layout
  localparam int WIN_MODE_W   = 3;
  localparam int TRIG_FLUSH   = 0;
  localparam int TRIG_START   = 1;
  localparam int POS_LSB      = 0;
  localparam int NEG_LSB      = 8;
  localparam int SCAN_LSB     = 16;
  localparam int OFFS_LSB     = 20;
  localparam int GAIN_LSB     = 24;
  localparam int CFG_CONTIN   = 0;
  localparam int CFG_WINEO    = 1;
  localparam int THR_LO_LSB   = 0;
  localparam int THR_HI_LSB   = 16;

  // writable masks, reserved bits read zero
  localparam logic [31:0] MASK_WINCMP  = 32'h0000_0007;
  localparam logic [31:0] MASK_INPUT   = 32'h0fff_1f1f;
  localparam logic [31:0] MASK_CONFIG  = 32'h0000_0003;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

  // ==================================================================
  // encodings
  localparam logic [2:0] WIN_OFF   = 3'h0;
  localparam logic [2:0] WIN_ABOVE = 3'h1;
  localparam logic [2:0] WIN_BELOW = 3'h2;
  localparam logic [2:0] WIN_IN    = 3'h3;
  localparam logic [2:0] WIN_OUT   = 3'h4;

  localparam logic [3:0] GAIN_X16  = 4'h4;
  localparam logic [3:0] GAIN_HALF = 4'hf;
  localparam logic [4:0] POS_PIN_MAX = 5'h13;
  localparam logic [4:0] POS_INT_LO  = 5'h18;
  localparam logic [4:0] POS_INT_HI  = 5'h1c;
  localparam logic [4:0] NEG_PIN_MAX = 5'h07;
  localparam logic [4:0] NEG_GND     = 5'h18;
  localparam logic [4:0] NEG_IOGND   = 5'h19;

  // ==================================================================
  // timing
  localparam int FLUSH_CYCLES = 2;

  typedef enum logic [3:0] {
    ADCWIN_IDLE  = 4'b0001,
    ADCWIN_CONV  = 4'b0010,
    ADCWIN_FLUSH = 4'b0100,
    ADCWIN_RESUM = 4'b1000
  } adcwin_state_t;

endpackage

// >>> tb/adcwin_core_model.sv
`timescale 1ns/1ps
module adcwin_core_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // control from the block; delay and value from the test
  input  wire logic        conv_start,
  input  wire logic        conv_flush,
  input  wire logic [7:0]  delay,
  input  wire logic [15:0] value,
  // answer to the block
  output logic             conv_done,
  output logic      [15:0] conv_result
);
  logic [7:0] cnt_ff;
  logic       busy_ff;
  // ====
  // conversion timing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy_ff <= 1'b0;
      cnt_ff <= 8'h00;
      conv_done <= 1'b0;
      conv_result <= 16'hffff;
    end else begin
      conv_done <= 1'b0;
      // result is only valid with done, so show no stale value
      conv_result <= ~value;
      if (conv_flush) begin
        busy_ff <= 1'b0;
      end else if (conv_start) begin
        busy_ff <= 1'b1;
        cnt_ff <= delay;
      end else if (busy_ff && cnt_ff == 8'h00) begin
        busy_ff <= 1'b0;
        conv_done <= 1'b1;
        conv_result <= value;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule

// >>> tb/adcwin_ctrl_monitor.sv
`timescale 1ns/1ps
module adcwin_chk (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        write_protect,
  // converter and events
  input wire logic        conv_start,
  input wire logic        conv_flush,
  input wire logic        conv_done,
  input wire logic [4:0]  mux_pos,
  input wire logic [4:0]  mux_neg,
  input wire logic [3:0]  gain_code,
  input wire logic        sel_invalid,
  input wire logic        window_hit_event
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic wr_ok;
  assign wr_ok = reg_wr && !write_protect;
  // ====
  // assertions
  win_rsvd_a: assert property ($past(reg_rd) && $past(reg_addr) == adcwin_pkg::ADDR_WINCMP
    |-> reg_rdata[31:3] == 29'h0) else $error("window control reserved bits set");
  trig_rsvd_a: assert property ($past(reg_rd) && $past(reg_addr) == adcwin_pkg::ADDR_TRIGGER
    |-> reg_rdata[31:2] == 30'h0) else $error("trigger reserved bits set");
  start_go_a: assert property (wr_ok && reg_addr == adcwin_pkg::ADDR_TRIGGER
    && reg_wdata[1:0] == 2'b10 |-> ##[1:100] conv_start) else $error("start write gave no conversion");
  start_one_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  flush_go_a: assert property (wr_ok && reg_addr == adcwin_pkg::ADDR_TRIGGER && reg_wdata[0]
    |-> ##[1:2] conv_flush) else $error("flush write gave no flush");
  flush_len_a: assert property ($rose(conv_flush) |-> conv_flush[*2] ##1 !conv_flush)
    else $error("flush length wrong");
  neg_gain_a: assert property (wr_ok && reg_addr == adcwin_pkg::ADDR_INPUT
    |=> mux_neg == $past(reg_wdata[12:8]) && gain_code == $past(reg_wdata[27:24]))
    else $error("negative select or gain not taken");
  pos_sum_a: assert property (wr_ok && reg_addr == adcwin_pkg::ADDR_INPUT
    |=> mux_pos == $past(reg_wdata[4:0]) + $past(reg_wdata[23:20])) else $error("positive sum wrong");
  gain_bad_a: assert property (wr_ok && reg_addr == adcwin_pkg::ADDR_INPUT
    && reg_wdata[27:24] inside {[5:14]} |=> sel_invalid) else $error("reserved gain not flagged");
  hit_cause_a: assert property (window_hit_event |-> $past(conv_done))
    else $error("window event without result");
  // ====
  // covers
  start_c: cover property (conv_start);
  flush_c: cover property ($rose(conv_flush));
  hit_c: cover property (window_hit_event);
endmodule
bind adcwin_ctrl adcwin_chk u_chk (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .write_protect, .conv_start, .conv_flush, .conv_done, .mux_pos, .mux_neg,
  .gain_code, .sel_invalid, .window_hit_event);

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
  logic        clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, write_protect = 0;
  logic [7:0]  reg_addr = 8'h00, delay = 8'h04;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, q;
  logic        conv_start, conv_flush, conv_done, sel_invalid, window_hit_event;
  logic [15:0] conv_result, value = 16'h0000;
  logic [4:0]  mux_pos, mux_neg;
  logic [3:0]  gain_code;
  int          fail_count = 0, n_compared = 0, n_start = 0, n_done = 0, n_hit = 0, cyc = 0;
  always #10 clk_sys = ~clk_sys;
  adcwin_ctrl dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .write_protect, .conv_start, .conv_flush, .conv_done, .conv_result, .mux_pos, .mux_neg,
    .gain_code, .sel_invalid, .window_hit_event);
  adcwin_core_model core (.clk_sys, .reset, .conv_start, .conv_flush, .delay, .value,
    .conv_done, .conv_result);
  // ====
  // event counters and hang limit
  always @(posedge clk_sys) begin
    cyc++;
    n_start += conv_start;
    n_done += conv_done;
    n_hit += window_hit_event;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  task results;
    $display("mismatches %0d compares %0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ====
  // bus and conversion helpers
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= d; reg_wr <= w; reg_rd <= !w;
    @(posedge clk_sys);
    reg_wr <= 1'b0; reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  task automatic wait_for(ref int c, input int goal);
    repeat (300) if (c < goal) @(posedge clk_sys);
    #1 `CHK("event count", goal, c)
  endtask
  task conv(input logic [15:0] v);
    value = v;
    bus(1'b1, adcwin_pkg::ADDR_TRIGGER, 32'h0000_0002);
    wait_for(n_done, n_done + 1);
    repeat (3) @(posedge clk_sys);
  endtask
  function logic hit(input int m, input int v);
    return m == 1 ? v > 100 : m == 2 ? v < 200 : m == 3 ? (v > 100 && v < 200) :
      m == 4 ? !(v > 100 && v < 200) : 1'b0;
  endfunction
  // ====
  // scenarios
  task t_regs;
    bus(1'b0, adcwin_pkg::ADDR_WINCMP, 0); `CHK("window reset", 32'h0000_0000, q)
    bus(1'b0, adcwin_pkg::ADDR_INPUT, 0); `CHK("input reset", 32'h0000_0000, q)
    bus(1'b0, 8'h04, 0); `CHK("unmapped", 32'h0000_0000, q)
    bus(1'b1, adcwin_pkg::ADDR_WINCMP, 32'hffff_ffff);
    bus(1'b0, adcwin_pkg::ADDR_WINCMP, 0); `CHK("window mode", 32'h0000_0007, q)
    bus(1'b1, adcwin_pkg::ADDR_INPUT, 32'hffff_ffff);
    bus(1'b0, adcwin_pkg::ADDR_INPUT, 0); `CHK("input", 32'h0fff_1f1f, q)
    write_protect = 1'b1;
    bus(1'b1, adcwin_pkg::ADDR_WINCMP, 32'h0000_0000);
    write_protect = 1'b0;
    bus(1'b0, adcwin_pkg::ADDR_WINCMP, 0); `CHK("protected", 32'h0000_0007, q)
  endtask
  task t_codes;
    logic [31:0] w [9] = '{32'h0400_0000, 32'h0500_0000, 32'h0f00_0000, 32'h0000_1800,
      32'h0000_1900, 32'h0000_0800, 32'h0000_0013, 32'h0000_0014, 32'h0000_001c};
    logic e [9] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, adcwin_pkg::ADDR_INPUT, w[i]);
      bus(1'b0, adcwin_pkg::ADDR_INPUT, 0); `CHK("input", w[i], q)
      `CHK("reserved code", e[i], sel_invalid)
    end
  endtask
  task t_window;
    int v [4] = '{100, 101, 199, 200};
    int h;
    bus(1'b1, adcwin_pkg::ADDR_INPUT, 32'h0000_0000);
    bus(1'b1, adcwin_pkg::ADDR_THRESH, 32'h00c8_0064);
    bus(1'b1, adcwin_pkg::ADDR_CONFIG, 32'h0000_0002);
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 4; k++) begin
        bus(1'b1, adcwin_pkg::ADDR_WINCMP, m);
        h = n_hit;
        conv(v[k]);
        `CHK("window hit", hit(m, v[k]), n_hit - h)
      end
    end
    bus(1'b1, adcwin_pkg::ADDR_CONFIG, 32'h0000_0000);
    bus(1'b1, adcwin_pkg::ADDR_WINCMP, 32'h0000_0001);
    h = n_hit;
    conv(16'h0096);
    `CHK("event off", 0, n_hit - h)
  endtask
  task t_scan;
    // reserved bits zero, range inside pins
    bus(1'b1, adcwin_pkg::ADDR_INPUT, 32'h0002_0002);
    for (int i = 0; i < 4; i++) begin
      `CHK("scan input", 5'(2 + i % 3), mux_pos)
      conv(16'h0000);
    end
    bus(1'b0, adcwin_pkg::ADDR_INPUT, 0); `CHK("offset wrap", 32'h0012_0002, q)
    bus(1'b1, adcwin_pkg::ADDR_INPUT, 32'h0000_0005);
    conv(16'h0000);
    `CHK("no scan", 5'h05, mux_pos)
  endtask
  task t_flush;
    int s;
    delay = 8'h1e;
    s = n_start;
    bus(1'b1, adcwin_pkg::ADDR_TRIGGER, 32'h0000_0002);
    wait_for(n_start, s + 1);
    bus(1'b1, adcwin_pkg::ADDR_TRIGGER, 32'h0000_0001);
    bus(1'b0, adcwin_pkg::ADDR_TRIGGER, 0); `CHK("flush bit", 1'b1, q[0])
    wait_for(n_start, s + 2);
    wait_for(n_done, n_done + 1);
    bus(1'b0, adcwin_pkg::ADDR_TRIGGER, 0); `CHK("trigger idle", 32'h0000_0000, q)
    delay = 8'h04;
    s = n_start;
    bus(1'b1, adcwin_pkg::ADDR_TRIGGER, 32'h0000_0000);
    repeat (10) @(posedge clk_sys);
    `CHK("zero write", s, n_start)
    bus(1'b1, adcwin_pkg::ADDR_CONFIG, 32'h0000_0001);
    bus(1'b1, adcwin_pkg::ADDR_TRIGGER, 32'h0000_0002);
    wait_for(n_start, s + 3);
    bus(1'b1, adcwin_pkg::ADDR_CONFIG, 32'h0000_0000);
    repeat (20) @(posedge clk_sys);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_codes();
    t_window();
    t_scan();
    t_flush();
    results();
  end
endmodule
